// ===== src/ppmi_pkg.sv
/*
 Shared constants and carrier types of the two-port pin mux and
 interrupt block. Assumes an 8-bit register port with 5-bit addresses.
*/
`default_nettype none
package ppmi_pkg;
   // Bus geometry
   localparam int DW = 8;
   localparam int AW = 5;
   // Port register banks: address bits [4:3] pick the port
   localparam logic [1:0] PORT1 = 2'h0;
   localparam logic [1:0] PORT2 = 2'h1;
   // Offsets inside a port bank
   localparam logic [2:0] O_IN = 3'h0;
   localparam logic [2:0] O_OUT = 3'h1;
   localparam logic [2:0] O_DIR = 3'h2;
   localparam logic [2:0] O_SEL = 3'h3;
   localparam logic [2:0] O_IE = 3'h4;
   localparam logic [2:0] O_IES = 3'h5;
   localparam logic [2:0] O_STAT = 3'h6;
   localparam logic [2:0] O_CLR = 3'h7;
   // Miscellaneous registers
   localparam logic [4:0] A_SET2 = 5'h10;
   localparam logic [4:0] A_CAPD = 5'h11;
   localparam logic [4:0] A_LCD_MODE_FIELD = 5'h12;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_CAPD = 2'h0;
   // LCD segment thresholds and supervisor level that steals a pin
   localparam logic [7:0] LCD_E0 = 8'hE0;
   localparam logic [7:0] LCD_C0 = 8'hC0;
   localparam logic [3:0] VLD_ALL = 4'hF;
   // Port two bits that a pin edge may set (unbonded bits excluded)
   localparam logic [7:0] HW_MASK2 = 8'h3F;

   // Register port request
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } ppmi_bus_t;

   // Software control of one port
   typedef struct packed {
      logic [7:0] out_l;
      logic [7:0] dir;
      logic [7:0] fsel;
      logic [7:0] ie;
      logic [7:0] ies;
   } ppmi_ctl_t;

   // Signals the peripherals drive toward the pins
   typedef struct packed {
      logic timer_out0;
      logic timer_out1;
      logic timer_out2;
      logic mclk_tap;
      logic aclk_tap;
      logic supervisor_output;
      logic serial_out_master_o;
      logic serial_in_master_o;
      logic serial_clock_o;
      logic uart_transmit;
      logic module_dir_serial_out;
      logic module_dir_serial_in;
      logic module_dir_serial_clock;
   } ppmi_mod_out_t;

   // Pin values handed to the peripherals
   typedef struct packed {
      logic capture_in0_a;
      logic capture_in0_b;
      logic capture_in1_a;
      logic timer_clock_input;
      logic serial_out_master_i;
      logic serial_in_master_i;
      logic capture_in2_a;
      logic serial_clock_i;
      logic slave_transmit_enable;
      logic uart_receive;
   } ppmi_mod_in_t;
endpackage
`default_nettype wire

// ===== src/ppmi_sync.sv
/*
 Two-flop synchroniser for a vector of pin inputs.
 Assumes the bits are independent levels; no word coherence is given.
*/
`timescale 1ns/10ps
`default_nettype none
module ppmi_sync #(
   parameter int W = 14
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   // First stage feeds only the second stage
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;
endmodule
`default_nettype wire

// ===== src/ppmi_top.sv
/*
 Pin multiplexing, direction control and edge interrupts of two 8-bit
 ports, with register port and one level interrupt.
 Assumes peripheral signals come from logic on mclk; pins are async.
*/
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
//Contract
//- Port one pins 0-1 work only while their cap disable bit is 0.
//- LCD pins become segments: P1.2-5, P2.0-1 at E0h, P1.6-7 at C0h.
//- Port two pins 2, 4, 5 always live, cap disable has no effect; pin 3 cut at level 1111b.
//- Function select drives peripheral signal; P1.1 main clock, P1.5 aux clock.
//- Peripheral direction: serial from module, transmit out, receive and enable in.
//- Unbonded port two pins 6-7 flags change only by software writes.
//- Unbonded input node held by a keeper, cleared at power-up clear.
module ppmi_top (
   input wire logic mclk,
   input wire logic rst,
   input wire ppmi_pkg::ppmi_bus_t bus,
   output logic [ppmi_pkg::DW-1:0] rdata_r,
   input wire logic [7:0] p1_pin_in,
   output logic [7:0] p1_pin_out_r,
   output logic [7:0] p1_pin_oe_r,
   input wire logic [5:0] p2_pin_in,
   output logic [5:0] p2_pin_out_r,
   output logic [5:0] p2_pin_oe_r,
   output logic [7:0] seg_sel_r,
   input wire ppmi_pkg::ppmi_mod_out_t mod_o,
   output ppmi_pkg::ppmi_mod_in_t mod_i_r,
   input wire logic [3:0] supervisor_level_field,
   output logic irq_r
);
   import ppmi_pkg::*;

   ppmi_ctl_t p1_r;
   ppmi_ctl_t p2_r;
   logic [7:0] f1_r;
   logic [7:0] f2_r;
   logic [1:0] capd_r;
   logic [7:0] lcd_mode_field_r;
   logic [7:0] v1_prev_r;
   logic [7:0] v2_prev_r;
   logic [1:0] keep_r;
   logic [1:0] keep_nxt;
   logic [13:0] pin_q;
   logic lcd_e;
   logic lcd_c;
   logic vld_f;
   logic [7:0] act1;
   logic [7:0] act2;
   logic [7:0] mo1;
   logic [7:0] mo2;
   logic [7:0] md1;
   logic [7:0] md2;
   logic [7:0] de1;
   logic [7:0] de2;
   logic [7:0] do1;
   logic [7:0] do2;
   logic [7:0] val1;
   logic [7:0] val2;
   logic [7:0] hs1;
   logic [7:0] hs2;
   logic [7:0] clr1;
   logic [7:0] clr2;
   logic [7:0] set2;

   // Address match inside a port bank
   function automatic logic port_hit(input ppmi_bus_t b, input logic [1:0] pt,
                                     input logic [2:0] off);
      return b.addr == {pt, off};
   endfunction

   // Edge detect: rising when select is 0, falling when 1
   function automatic logic [7:0] edge_hit(input logic [7:0] cur,
                                           input logic [7:0] prv,
                                           input logic [7:0] ies);
      return (~ies & cur & ~prv) | (ies & ~cur & prv);
   endfunction

   // Control register write for one port bank
   function automatic ppmi_ctl_t ctl_wr(input ppmi_ctl_t c, input ppmi_bus_t b,
                                        input logic [1:0] pt);
      ppmi_ctl_t n;
      n = c;
      if (b.wr) begin
         if (port_hit(b, pt, O_OUT)) begin
            n.out_l = b.wdata;
         end else if (port_hit(b, pt, O_DIR)) begin
            n.dir = b.wdata;
         end else if (port_hit(b, pt, O_SEL)) begin
            n.fsel = b.wdata;
         end else if (port_hit(b, pt, O_IE)) begin
            n.ie = b.wdata;
         end else if (port_hit(b, pt, O_IES)) begin
            n.ies = b.wdata;
         end
      end
      return n;
   endfunction

   // Read mux for one port bank; clear register reads as zero
   function automatic logic [7:0] port_rd(input ppmi_ctl_t c, input logic [7:0] v,
                                          input logic [7:0] f, input ppmi_bus_t b,
                                          input logic [1:0] pt);
      logic [7:0] r;
      r = RST_BYTE;
      if (port_hit(b, pt, O_IN)) begin
         r = v;
      end else if (port_hit(b, pt, O_OUT)) begin
         r = c.out_l;
      end else if (port_hit(b, pt, O_DIR)) begin
         r = c.dir;
      end else if (port_hit(b, pt, O_SEL)) begin
         r = c.fsel;
      end else if (port_hit(b, pt, O_IE)) begin
         r = c.ie;
      end else if (port_hit(b, pt, O_IES)) begin
         r = c.ies;
      end else if (port_hit(b, pt, O_STAT)) begin
         r = f;
      end
      return r;
   endfunction

   // Pin inputs cross into mclk
   ppmi_sync #(.W(14)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d({p2_pin_in, p1_pin_in}),
      .q(pin_q)
   );

   // Which pins keep their port function
   always_comb begin
      lcd_e = lcd_mode_field_r >= LCD_E0;
      lcd_c = lcd_mode_field_r >= LCD_C0;
      vld_f = supervisor_level_field == VLD_ALL;
      act1 = {{2{!lcd_c}}, {4{!lcd_e}}, ~capd_r};
      act2 = {4'hF, !vld_f, 1'h1, {2{!lcd_e}}};
   end

   // Peripheral outputs and module directions per pin
   always_comb begin
      mo1 = {mod_o.serial_in_master_o, mod_o.serial_out_master_o, mod_o.aclk_tap,
             1'h0, mod_o.supervisor_output, mod_o.timer_out1, mod_o.mclk_tap,
             mod_o.timer_out0};
      mo2 = {3'h0, mod_o.uart_transmit, 2'h0, mod_o.serial_clock_o,
             mod_o.timer_out2};
      md1 = {mod_o.module_dir_serial_in, mod_o.module_dir_serial_out,
             p1_r.dir[5:0]};
      md2 = {p2_r.dir[7:6], 1'h0, 1'h1, p2_r.dir[3], 1'h0,
             mod_o.module_dir_serial_clock, p2_r.dir[0]};
   end

   // Function select picks peripheral or latch
   always_comb begin
      de1 = (p1_r.fsel & md1) | (~p1_r.fsel & p1_r.dir);
      de2 = (p2_r.fsel & md2) | (~p2_r.fsel & p2_r.dir);
      do1 = (p1_r.fsel & mo1) | (~p1_r.fsel & p1_r.out_l);
      do2 = (p2_r.fsel & mo2) | (~p2_r.fsel & p2_r.out_l);
   end

   // Input values: cut pins read 0, unbonded pins read the keeper
   always_comb begin
      val1 = act1 & pin_q[7:0];
      val2 = {keep_r, act2[5:0] & pin_q[13:8]};
   end

   // Keeper follows the internal drive, else holds
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_keep
         assign keep_nxt[gi] = de2[6+gi] ? do2[6+gi] : keep_r[gi];
      end
   endgenerate

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         keep_r <= 2'h0;
      end else begin
         keep_r <= keep_nxt;
      end
   end

   // Flag events and software masks
   always_comb begin
      hs1 = edge_hit(val1, v1_prev_r, p1_r.ies);
      hs2 = edge_hit(val2, v2_prev_r, p2_r.ies) & HW_MASK2;
      clr1 = (bus.wr && port_hit(bus, PORT1, O_CLR)) ? bus.wdata : RST_BYTE;
      clr2 = (bus.wr && port_hit(bus, PORT2, O_CLR)) ? bus.wdata : RST_BYTE;
      set2 = (bus.wr && bus.addr == A_SET2) ? bus.wdata : RST_BYTE;
   end

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         f1_r <= RST_BYTE;
         f2_r <= RST_BYTE;
         v1_prev_r <= RST_BYTE;
         v2_prev_r <= RST_BYTE;
      end else begin
         f1_r <= (f1_r & ~clr1) | hs1;
         f2_r <= (f2_r & ~clr2) | set2 | hs2;
         v1_prev_r <= val1;
         v2_prev_r <= val2;
      end
   end

   // Port control registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         p1_r <= '0;
         p2_r <= '0;
      end else begin
         p1_r <= ctl_wr(p1_r, bus, PORT1);
         p2_r <= ctl_wr(p2_r, bus, PORT2);
      end
   end

   // Cap disable and LCD mode registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         capd_r <= RST_CAPD;
         lcd_mode_field_r <= RST_BYTE;
      end else if (bus.wr) begin
         if (bus.addr == A_CAPD) begin
            capd_r <= bus.wdata[1:0];
         end else if (bus.addr == A_LCD_MODE_FIELD) begin
            lcd_mode_field_r <= bus.wdata;
         end
      end
   end

   // Read data stand one cycle after the strobe only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_r <= RST_BYTE;
      end else if (!bus.rd) begin
         rdata_r <= RST_BYTE;
      end else if (bus.addr[4:3] == PORT1) begin
         rdata_r <= port_rd(p1_r, val1, f1_r, bus, PORT1);
      end else if (bus.addr[4:3] == PORT2) begin
         rdata_r <= port_rd(p2_r, val2, f2_r, bus, PORT2);
      end else if (bus.addr == A_CAPD) begin
         rdata_r <= {6'h00, capd_r};
      end else if (bus.addr == A_LCD_MODE_FIELD) begin
         rdata_r <= lcd_mode_field_r;
      end else begin
         rdata_r <= RST_BYTE;
      end
   end

   // Pin drivers; a cut pin neither drives nor enables
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         p1_pin_out_r <= RST_BYTE;
         p1_pin_oe_r <= RST_BYTE;
         p2_pin_out_r <= 6'h00;
         p2_pin_oe_r <= 6'h00;
         seg_sel_r <= RST_BYTE;
      end else begin
         p1_pin_out_r <= act1 & do1;
         p1_pin_oe_r <= act1 & de1;
         p2_pin_out_r <= act2[5:0] & do2[5:0];
         p2_pin_oe_r <= act2[5:0] & de2[5:0];
         seg_sel_r <= {{2{lcd_e}}, {2{lcd_c}}, {4{lcd_e}}};
      end
   end

   // Pin values to the peripherals
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mod_i_r <= '0;
      end else begin
         mod_i_r.capture_in0_a <= val1[0];
         mod_i_r.capture_in0_b <= val1[1];
         mod_i_r.capture_in1_a <= val1[2];
         mod_i_r.timer_clock_input <= val1[5];
         mod_i_r.serial_out_master_i <= val1[6];
         mod_i_r.serial_in_master_i <= val1[7];
         mod_i_r.capture_in2_a <= val2[0];
         mod_i_r.serial_clock_i <= val2[1];
         mod_i_r.slave_transmit_enable <= val2[2];
         mod_i_r.uart_receive <= val2[5];
      end
   end

   // Level interrupt while any enabled flag is set
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'h0;
      end else begin
         irq_r <= |((f1_r & p1_r.ie) | (f2_r & p2_r.ie));
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_capd;
      capd_r[0] |=> !p1_pin_oe_r[0] && !p1_pin_out_r[0];
   endproperty
   a_capd: assert property (p_capd) else $error("cut pin still driven");

   property p_lcd;
      (lcd_mode_field_r >= LCD_E0) |=> seg_sel_r[5:0] == 6'h3F && p1_pin_oe_r[5:2] == 4'h0;
   endproperty
   a_lcd: assert property (p_lcd) else $error("segment pin not taken");

   property p_lcd_c;
      (lcd_mode_field_r >= LCD_C0 && lcd_mode_field_r < LCD_E0) |=> seg_sel_r == 8'h30;
   endproperty
   a_lcd_c: assert property (p_lcd_c) else $error("wrong segment split");

   property p_vld;
      (supervisor_level_field == VLD_ALL) |=> !p2_pin_oe_r[3];
   endproperty
   a_vld: assert property (p_vld) else $error("level pin still driven");

   property p_mclk;
      (p1_r.fsel[1] && !capd_r[1]) |=> p1_pin_out_r[1] == $past(mod_o.mclk_tap);
   endproperty
   a_mclk: assert property (p_mclk) else $error("clock pin wrong");

   property p_dir;
      (p2_r.fsel[5:4] == 2'h3 && p2_r.fsel[2]) |=> p2_pin_oe_r[5:4] == 2'h1 && !p2_pin_oe_r[2];
   endproperty
   a_dir: assert property (p_dir) else $error("forced direction wrong");

   property p_sw;
      (f2_r[7:6] != $past(f2_r[7:6])) |->
         $past(bus.wr && (bus.addr == A_SET2 || port_hit(bus, PORT2, O_CLR)));
   endproperty
   a_sw: assert property (p_sw) else $error("unbonded flag moved alone");

   property p_keep;
      !de2[6] |=> $stable(keep_r[0]);
   endproperty
   a_keep: assert property (p_keep) else $error("keeper did not hold");

   sequence s_rise0;
      !val1[0] ##1 val1[0];
   endsequence
   property p_edge;
      (!p1_r.ies[0] throughout s_rise0) |=> f1_r[0] ##1 irq_r || !p1_r.ie[0];
   endproperty
   a_edge: assert property (p_edge) else $error("rising edge lost");
endmodule
`default_nettype wire

// ===== dv/ppmi_periph_model.sv
/*
 Peripheral side model: timer, serial and clock outputs as flopped levels.
 Assumes the bench sets the wanted pattern; it shows one mclk later.
*/
`timescale 1ns/10ps
`default_nettype none
module ppmi_periph_model (
   input wire logic mclk,
   input wire logic rst,
   input wire ppmi_pkg::ppmi_mod_out_t pat,
   output ppmi_pkg::ppmi_mod_out_t mod_o
);
   import ppmi_pkg::*;
   // Peripheral levels come from flops on the system clock
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mod_o <= '0;
      end else begin
         mod_o <= pat;
      end
   end
endmodule
`default_nettype wire

// ===== dv/ppmi_top_tb.sv
/*
 Self-checking bench of the pin mux and interrupt block.
 Assumes the peripheral model beside it; reads are checked from a queue.
*/
`timescale 1ns/10ps
`default_nettype none
module ppmi_top_tb;
   import ppmi_pkg::*;
   logic mclk, rst, irq, rd_d;
   ppmi_bus_t bus;
   logic [7:0] rdata_r, p1_in, p1_out, p1_oe, seg, r;
   logic [5:0] p2_in, p2_out, p2_oe;
   ppmi_mod_out_t pat, mod_o;
   ppmi_mod_in_t mod_i;
   logic [3:0] lvl;
   logic [7:0] exp_q[$];
   logic [15:0] lcd_tab[4] = '{16'hBF00, 16'hC030, 16'hDF30, 16'hE0FF};
   logic [31:0] seed;
   int failures, checks_done, cycles;

   ppmi_top i_ppmi_top (.mclk(mclk), .rst(rst), .bus(bus), .rdata_r(rdata_r),
      .p1_pin_in(p1_in), .p1_pin_out_r(p1_out), .p1_pin_oe_r(p1_oe),
      .p2_pin_in(p2_in), .p2_pin_out_r(p2_out), .p2_pin_oe_r(p2_oe),
      .seg_sel_r(seg), .mod_o(mod_o), .mod_i_r(mod_i), .supervisor_level_field(lvl),
      .irq_r(irq));
   ppmi_periph_model i_ppmi_periph_model (.mclk(mclk), .rst(rst), .pat(pat), .mod_o(mod_o));

   // Clock, 50 ns period
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic note(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      note(got, exp);
   endtask
   task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      note(got, exp);
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Write strobe for one cycle, then let pins settle
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk) bus <= '0;
      repeat (2) @(posedge mclk);
   endtask
   // Read strobe; the expected byte waits in the queue
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      exp_q.push_back(e);
      @(posedge mclk) bus <= '0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic pins(input logic [7:0] v);
      @(posedge mclk) p1_in <= v;
      repeat (6) @(posedge mclk);
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge mclk) begin
      rd_d <= bus.rd;
      if (rd_d) begin
         cmp_rd(rdata_r, exp_q.pop_front());
      end
   end

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         stop_test();
      end
   end

   initial begin
      seed = 32'hA043F7ED;
      bus = '0;
      p1_in = 8'h00;
      p2_in = 6'h00;
      pat = '0;
      lvl = 4'h0;
      rst = 1'b1;
      failures = 0;
      checks_done = 0;
      cycles = 0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rd(5'h08, 8'h00);
      rd(5'h01, RST_BYTE);
      $display("test reset finished");
      wr(5'h04, 8'h03);
      wr(5'h05, 8'h02);
      pins(8'h01);
      pins(8'h03);
      pins(8'h01);
      rd(5'h06, 8'h03);
      cmp_pin({7'h00, irq}, 8'h01);
      wr(5'h07, 8'h03);
      cmp_pin({7'h00, irq}, 8'h00);
      $display("test pin edges finished");
      wr(A_SET2, 8'hC0);
      rd(5'h0E, 8'hC0);
      cmp_pin({7'h00, irq}, 8'h00);
      wr(5'h0C, 8'hC0);
      cmp_pin({7'h00, irq}, 8'h01);
      wr(5'h0F, 8'hC0);
      cmp_pin({7'h00, irq}, 8'h00);
      // Keeper nodes driven high must not raise the unbonded flags
      wr(5'h09, 8'hC0);
      wr(5'h0A, 8'hC0);
      rd(5'h08, 8'hC0);
      rd(5'h0E, 8'h00);
      $display("test soft interrupts finished");
      r = 8'($random(seed));
      pat.mclk_tap <= ~r[1];
      pat.aclk_tap <= ~r[5];
      pat.module_dir_serial_out <= 1'b1;
      pat.uart_transmit <= 1'b1;
      wr(5'h01, r);
      wr(5'h02, 8'hFF);
      cmp_pin(p1_out, r);
      wr(5'h03, 8'h22);
      cmp_pin(p1_out, r ^ 8'h22);
      wr(5'h02, 8'h3F);
      wr(5'h03, 8'hC0);
      cmp_pin(p1_oe, 8'h7F);
      wr(5'h0A, 8'h24);
      wr(5'h0B, 8'h34);
      cmp_pin({2'b00, p2_oe}, 8'h10);
      cmp_pin({2'b00, p2_out}, 8'h10);
      // Forced-input pins still hand their level to the module
      @(posedge mclk) p2_in <= 6'h24;
      repeat (4) @(posedge mclk);
      cmp_pin({6'h00, mod_i.uart_receive, mod_i.slave_transmit_enable}, 8'h03);
      rd(5'h0E, 8'h24);
      $display("test peripheral select finished");
      wr(5'h0A, 8'h08);
      wr(5'h0B, 8'h00);
      cmp_pin({2'b00, p2_oe}, 8'h08);
      @(posedge mclk) lvl <= 4'hF;
      repeat (3) @(posedge mclk);
      cmp_pin({2'b00, p2_oe}, 8'h00);
      wr(5'h03, 8'h00);
      wr(5'h02, 8'hFF);
      wr(A_CAPD, 8'h01);
      cmp_pin(p1_oe, 8'hFE);
      rd(5'h00, 8'h00);
      $display("test cap disable finished");
      foreach (lcd_tab[i]) begin
         wr(A_LCD_MODE_FIELD, lcd_tab[i][15:8]);
         cmp_pin(seg, lcd_tab[i][7:0]);
      end
      cmp_pin(p1_oe, 8'h02);
      $display("test segment select finished");
      // Second reset clears the held keeper nodes
      @(posedge mclk) rst <= 1'b1;
      @(posedge mclk) rst <= 1'b0;
      repeat (3) @(posedge mclk);
      cmp_pin(seg, 8'h00);
      rd(5'h08, 8'h24);
      $display("test second reset finished");
      stop_test();
   end
endmodule
`default_nettype wire
